// ===== src/cax_core.sv
// add / add-with-carry / word add and io bit set/clear execution
// assumes one request per issue when ready; io flags supplied by peripherals
// Notes on behaviour
// - register add writes sum, flags, one clock
// - word add on pair, flags, two clocks
// - writing one clears write-one-clear flags
// - bit ops write back whole register
// - bit ops reach io 0x00 to 0x1f
`timescale 1ns/1ps
module cax_core
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// instruction request
	input wire cax_pkg::cax_req_t req,
	input wire logic req_valid,
	output logic req_ready,
	// io read data for the addressed register
	input wire logic [7:0] io_rdata,
	// io write toward peripherals
	output cax_pkg::cax_io_wr_t io_wr,
	// observation
	output logic [7:0] sreg,
	output logic done
);
	logic [7:0] regs_reg [cax_pkg::REG_COUNT]; // working registers
	logic [7:0] sreg_reg; // status flags
	logic busy_reg; // second cycle of word add
	logic ready_reg; // registered ready, low while a word add finishes
	logic done_reg; // completion pulse
	logic [15:0] word_reg; // word add second-half staging
	logic [4:0] wlo_reg; // pair low register index
	cax_pkg::cax_io_wr_t io_wr_reg;
	logic [7:0] a_in, b_in, s_out;
	logic cin, co, hc, ov;
	logic take;
	// stall for the second word cycle
	assign take = req_valid && !busy_reg;
	assign req_ready = ready_reg;
	// operand selection for the shared adder
	always_comb
	begin
		a_in = regs_reg[req.dst];
		b_in = regs_reg[req.src];
		cin = (req.op == cax_pkg::CAX_OP_ADC) ? sreg_reg[cax_pkg::FLAG_C] : 1'b0;
	end
	cax_adder u_add
	(
		.a(a_in),
		.b(b_in),
		.cin(cin),
		.sum(s_out),
		.cout(co),
		.half(hc),
		.ovf(ov)
	);
	function automatic logic [4:0] pair_low(input logic [4:0] sel);
		pair_low = cax_pkg::WORD_BASE + {2'b00, sel[1:0], 1'b0};
	endfunction : pair_low
	logic [15:0] wsum;
	logic [4:0] plo;
	// word operand taken from the pair, high:low
	always_comb
	begin
		plo = pair_low(req.dst);
		wsum = {regs_reg[plo + 5'h01], regs_reg[plo]} + {10'h000, req.imm};
	end
	// register file updates
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < cax_pkg::REG_COUNT; i++)
				regs_reg[i] <= cax_pkg::REG_RESET;
		end
		else if (take && (req.op == cax_pkg::CAX_OP_ADD || req.op == cax_pkg::CAX_OP_ADC))
		begin
			regs_reg[req.dst] <= s_out;
		end
		else if (take && req.op == cax_pkg::CAX_OP_WORD)
		begin
			regs_reg[plo] <= wsum[7:0];
		end
		else if (busy_reg)
		begin
			regs_reg[wlo_reg + 5'h01] <= word_reg[15:8];
		end
	end
	// word add sequencing
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			busy_reg <= 1'b0;
			word_reg <= 16'h0000;
			wlo_reg <= 5'h00;
		end
		else
		begin
			busy_reg <= take && req.op == cax_pkg::CAX_OP_WORD;
			if (take && req.op == cax_pkg::CAX_OP_WORD)
			begin
				word_reg <= wsum;
				wlo_reg <= plo;
			end
		end
	end
	// ready drops for the cycle that finishes a word add
	// kept in its own flop so the port has no gate in front of it
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			ready_reg <= 1'b1;
		else
			ready_reg <= !(take && req.op == cax_pkg::CAX_OP_WORD);
	end
	// status flag updates
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			sreg_reg <= cax_pkg::SREG_RESET;
		else if (take && (req.op == cax_pkg::CAX_OP_ADD || req.op == cax_pkg::CAX_OP_ADC))
		begin
			// z c n v h, sign follows n xor v
			sreg_reg[cax_pkg::FLAG_C] <= co;
			sreg_reg[cax_pkg::FLAG_Z] <= (s_out == 8'h00);
			sreg_reg[cax_pkg::FLAG_N] <= s_out[7];
			sreg_reg[cax_pkg::FLAG_V] <= ov;
			sreg_reg[cax_pkg::FLAG_S] <= s_out[7] ^ ov;
			sreg_reg[cax_pkg::FLAG_H] <= hc;
		end
		else if (busy_reg)
		begin
			// z c n v s from the whole word, h kept
			sreg_reg[cax_pkg::FLAG_C] <= ~word_reg[15] & regs_reg[wlo_reg + 5'h01][7];
			sreg_reg[cax_pkg::FLAG_Z] <= (word_reg == 16'h0000);
			sreg_reg[cax_pkg::FLAG_N] <= word_reg[15];
			sreg_reg[cax_pkg::FLAG_V] <= word_reg[15] & ~regs_reg[wlo_reg + 5'h01][7];
			sreg_reg[cax_pkg::FLAG_S] <= word_reg[15] ^
				(word_reg[15] & ~regs_reg[wlo_reg + 5'h01][7]);
		end
	end
	// io bit set/clear, read-modify-write of the full byte
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			io_wr_reg <= '0;
		// only the low io range is reachable
		else if (take && req.imm <= cax_pkg::IO_BIT_MAX &&
			(req.op == cax_pkg::CAX_OP_SETB || req.op == cax_pkg::CAX_OP_CLRB))
		begin
			io_wr_reg.we <= 1'b1;
			io_wr_reg.addr <= req.imm[4:0];
			// every other bit written back as read
			// set flags read back as one, so they clear
			if (req.op == cax_pkg::CAX_OP_SETB)
				io_wr_reg.data <= io_rdata | (8'h01 << req.bitn);
			else
				io_wr_reg.data <= io_rdata & ~(8'h01 << req.bitn);
		end
		else
			io_wr_reg.we <= 1'b0;
	end
	// completion pulse: add at once, word after second cycle
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			done_reg <= 1'b0;
		else
			done_reg <= busy_reg || (take && req.op != cax_pkg::CAX_OP_NONE &&
				req.op != cax_pkg::CAX_OP_WORD);
	end
	assign io_wr = io_wr_reg;
	assign sreg = sreg_reg;
	assign done = done_reg;
	// checks
	property p_add_one;
		@(posedge core_clk) disable iff (!rst_b)
		take && req.op == cax_pkg::CAX_OP_ADD |=> done && regs_reg[$past(req.dst)] == $past(s_out);
	endproperty
	a_add_one: assert property (p_add_one) else $error("add not done in one clock");
	property p_add_zero;
		@(posedge core_clk) disable iff (!rst_b)
		take && req.op == cax_pkg::CAX_OP_ADC |=>
		sreg[cax_pkg::FLAG_Z] == (regs_reg[$past(req.dst)] == 8'h00);
	endproperty
	a_add_zero: assert property (p_add_zero) else $error("zero flag wrong after add");
	property p_word_two;
		@(posedge core_clk) disable iff (!rst_b)
		take && req.op == cax_pkg::CAX_OP_WORD |=> !done && !req_ready ##1 done && req_ready;
	endproperty
	a_word_two: assert property (p_word_two) else $error("word add not two clocks");
	property p_word_val;
		@(posedge core_clk) disable iff (!rst_b)
		take && req.op == cax_pkg::CAX_OP_WORD |-> ##2
		{regs_reg[$past(plo, 2) + 5'h01], regs_reg[$past(plo, 2)]} == $past(wsum, 2);
	endproperty
	a_word_val: assert property (p_word_val) else $error("word add result wrong");
	property p_rmw;
		@(posedge core_clk) disable iff (!rst_b)
		take && req.op == cax_pkg::CAX_OP_CLRB && req.imm <= cax_pkg::IO_BIT_MAX |=>
		io_wr.we && io_wr.data == ($past(io_rdata) & ~(8'h01 << $past(req.bitn)));
	endproperty
	a_rmw: assert property (p_rmw) else $error("bit op lost other bits");
	property p_w1c;
		@(posedge core_clk) disable iff (!rst_b)
		take && req.op == cax_pkg::CAX_OP_SETB && req.imm <= cax_pkg::IO_BIT_MAX |=>
		io_wr.we && io_wr.data == ($past(io_rdata) | (8'h01 << $past(req.bitn)));
	endproperty
	a_w1c: assert property (p_w1c) else $error("set flag not written back as one");
	property p_range;
		@(posedge core_clk) disable iff (!rst_b)
		take && req.imm > cax_pkg::IO_BIT_MAX |=> !io_wr.we;
	endproperty
	a_range: assert property (p_range) else $error("bit op outside low io range");
	c_add: cover property (@(posedge core_clk) take && req.op == cax_pkg::CAX_OP_ADC);
	c_word: cover property (@(posedge core_clk) take && req.op == cax_pkg::CAX_OP_WORD);
	c_clr: cover property (@(posedge core_clk) take && req.op == cax_pkg::CAX_OP_CLRB);
	c_far: cover property (@(posedge core_clk) take && req.imm > cax_pkg::IO_BIT_MAX &&
		req.op == cax_pkg::CAX_OP_SETB);
endmodule : cax_core

// ===== src/cax_pkg.sv
// package for the add and io-bit execution block
// assumes a single core clock; nothing here is clocked
package cax_pkg;
	// register file geometry
	localparam int unsigned REG_COUNT = 32;
	localparam int unsigned REG_AW = 5;
	localparam int unsigned IO_COUNT = 32;
	localparam int unsigned IO_AW = 5;
	// highest io address reachable by bit set/clear
	localparam logic [5:0] IO_BIT_MAX = 6'h1f;
	// word add constant is six bits, pair base r24
	localparam logic [4:0] WORD_BASE = 5'h18;
	// sreg bit positions
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;
	localparam logic [7:0] SREG_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;
	// cycles per operation
	localparam int unsigned ADD_CYCLES = 1;
	localparam int unsigned WORD_CYCLES = 2;
	// operation codes
	typedef enum logic [2:0] {
		CAX_OP_NONE = 3'b000,
		CAX_OP_ADD = 3'b001,
		CAX_OP_ADC = 3'b010,
		CAX_OP_WORD = 3'b011,
		CAX_OP_SETB = 3'b100,
		CAX_OP_CLRB = 3'b101
	} cax_op_t;
	// one instruction request
	typedef struct packed {
		cax_op_t op;
		logic [4:0] dst; // destination, or pair selector in [1:0]
		logic [4:0] src; // source register
		logic [5:0] imm; // word constant, or io address
		logic [2:0] bitn; // bit index for io ops
	} cax_req_t;
	// io write port toward peripherals
	typedef struct packed {
		logic we;
		logic [4:0] addr;
		logic [7:0] data;
	} cax_io_wr_t;
endpackage : cax_pkg

// ===== src/cax_adder.sv
// 8-bit adder with flag generation, purely combinational
// assumes caller picks carry-in and which flags to keep
`timescale 1ns/1ps
module cax_adder
(
	// operands
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	// results
	output logic [7:0] sum,
	output logic cout,
	output logic half,
	output logic ovf
);
	logic [8:0] full; // nine-bit sum holds carry
	logic [4:0] low; // low nibble sum for half carry
	always_comb
	begin
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		sum = full[7:0];
		cout = full[8];
		half = low[4];
		// signs alike in, different out
		ovf = (a[7] == b[7]) && (full[7] != a[7]);
	end
endmodule : cax_adder

// ===== tb/tb_top.sv
// self-checking bench for the add and io bit execution core
// assumes cax_core has no parameters and runs from one 50 MHz clock
`timescale 1ns/1ps
module tb_top;
	// one stimulus row: request, io value, latency, flag mask and value, io write
	typedef struct {
		cax_pkg::cax_req_t r;
		logic [7:0] rd;
		int lat;
		logic [7:0] msk;
		logic [7:0] fl;
		logic we;
		logic [7:0] wd;
	} cax_row_t;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	cax_pkg::cax_req_t req = '0;
	logic req_valid = 1'b0;
	logic req_ready;
	logic [7:0] io_rdata = 8'h00;
	cax_pkg::cax_io_wr_t io_wr;
	logic [7:0] sreg;
	logic done;
	int err_total = 0;
	int checks = 0;
	cax_row_t rows[$];
	cax_row_t w;

	cax_core u_dut (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.req(req),
		.req_valid(req_valid),
		.req_ready(req_ready),
		.io_rdata(io_rdata),
		.io_wr(io_wr),
		.sreg(sreg),
		.done(done)
	);

	// free-running 20 ns clock
	initial forever #10 core_clk = ~core_clk;

	// compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// single place where the run ends
	task automatic test_done();
		$display("mismatches %0d, checks %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done

	task automatic row(input cax_pkg::cax_op_t op, input logic [4:0] d, input logic [4:0] s,
		input logic [5:0] k, input logic [2:0] b, input logic [7:0] rd, input int lat,
		input logic [7:0] msk, input logic [7:0] fl, input logic we, input logic [7:0] wd);
		cax_row_t x;
		x.r.op = op;
		x.r.dst = d;
		x.r.src = s;
		x.r.imm = k;
		x.r.bitn = b;
		x.rd = rd;
		x.lat = lat;
		x.msk = msk;
		x.fl = fl;
		x.we = we;
		x.wd = wd;
		rows.push_back(x);
	endtask : row

	// issue one op, hold io value, then check timing, flags and io write
	task automatic run(input cax_row_t x);
		int n;
		@(negedge core_clk);
		req = x.r;
		io_rdata = x.rd;
		req_valid = 1'b1;
		@(negedge core_clk);
		req_valid = 1'b0;
		chk({7'h00, req_ready}, (x.lat == 2) ? 8'h00 : 8'h01, "ready");
		n = 1;
		while (done !== 1'b1 && n < 6)
		begin
			n++;
			@(negedge core_clk);
		end
		chk(n[7:0], x.lat[7:0], "latency");
		chk(sreg & x.msk, x.fl, "flags");
		chk({7'h00, io_wr.we}, {7'h00, x.we}, "io we");
		if (x.we)
		begin
			chk({3'h0, io_wr.addr}, {3'h0, x.r.imm[4:0]}, "io addr");
			chk(io_wr.data, x.wd, "io data");
		end
		@(negedge core_clk);
		chk({7'h00, io_wr.we | done}, 8'h00, "pulse");
	endtask : run

	initial
	begin
		// no reserved io address is ever written below
		row(cax_pkg::CAX_OP_WORD, 5'h00, 5'h00, 6'h3f, 3'h0, 8'h00, 2, 8'h1f, 8'h00, 1'b0, 8'h00);
		row(cax_pkg::CAX_OP_ADD, 5'h18, 5'h18, 6'h00, 3'h0, 8'h00, 1, 8'hff, 8'h20, 1'b0, 8'h00);
		row(cax_pkg::CAX_OP_ADD, 5'h18, 5'h18, 6'h00, 3'h0, 8'h00, 1, 8'hff, 8'h2c, 1'b0, 8'h00);
		row(cax_pkg::CAX_OP_ADD, 5'h18, 5'h18, 6'h00, 3'h0, 8'h00, 1, 8'hff, 8'h35, 1'b0, 8'h00);
		row(cax_pkg::CAX_OP_ADC, 5'h00, 5'h00, 6'h00, 3'h0, 8'h00, 1, 8'hff, 8'h00, 1'b0, 8'h00);
		row(cax_pkg::CAX_OP_WORD, 5'h00, 5'h00, 6'h3f, 3'h0, 8'h00, 2, 8'h1f, 8'h00, 1'b0, 8'h00);
		row(cax_pkg::CAX_OP_ADD, 5'h19, 5'h19, 6'h00, 3'h0, 8'h00, 1, 8'hff, 8'h00, 1'b0, 8'h00);
		row(cax_pkg::CAX_OP_ADD, 5'h01, 5'h01, 6'h00, 3'h0, 8'h00, 1, 8'hff, 8'h02, 1'b0, 8'h00);
		row(cax_pkg::CAX_OP_WORD, 5'h03, 5'h00, 6'h00, 3'h0, 8'h00, 2, 8'h1f, 8'h02, 1'b0, 8'h00);
		row(cax_pkg::CAX_OP_SETB, 5'h00, 5'h00, 6'h00, 3'h0, 8'h00, 1, 8'h00, 8'h00, 1'b1, 8'h01);
		// io values and picked bits leave reserved bits at zero
		row(cax_pkg::CAX_OP_SETB, 5'h00, 5'h00, 6'h18, 3'h7, 8'h41, 1, 8'h00, 8'h00, 1'b1, 8'hc1);
		row(cax_pkg::CAX_OP_CLRB, 5'h00, 5'h00, 6'h0e, 3'h0, 8'h81, 1, 8'h00, 8'h00, 1'b1, 8'h80);
		row(cax_pkg::CAX_OP_CLRB, 5'h00, 5'h00, 6'h18, 3'h3, 8'hff, 1, 8'h00, 8'h00, 1'b1, 8'hf7);
		row(cax_pkg::CAX_OP_SETB, 5'h00, 5'h00, 6'h1f, 3'h0, 8'h00, 1, 8'h00, 8'h00, 1'b1, 8'h01);
		row(cax_pkg::CAX_OP_SETB, 5'h00, 5'h00, 6'h20, 3'h1, 8'h00, 1, 8'h00, 8'h00, 1'b0, 8'h00);
		row(cax_pkg::CAX_OP_CLRB, 5'h00, 5'h00, 6'h3f, 3'h2, 8'hff, 1, 8'h00, 8'h00, 1'b0, 8'h00);
		repeat (12) @(negedge core_clk);
		rst_b = 1'b1;
		chk(sreg, 8'h00, "reset flags");
		chk({6'h00, done, io_wr.we}, 8'h00, "reset pulses");
		foreach (rows[i]) run(rows[i]);
		// empty op must not complete
		@(negedge core_clk);
		req.op = cax_pkg::CAX_OP_NONE;
		req_valid = 1'b1;
		@(negedge core_clk);
		req_valid = 1'b0;
		chk({7'h00, done}, 8'h00, "none op");
		// reset in mid-run clears the working registers too
		rst_b = 1'b0;
		@(negedge core_clk);
		chk(sreg, 8'h00, "mid reset");
		rst_b = 1'b1;
		w = rows[1];
		w.fl = 8'h02;
		run(w);
		test_done();
	end

	// watchdog sized well beyond the expected seventy or so cycles
	initial
	begin
		#50us;
		err_total++;
		test_done();
	end
endmodule : tb_top
